/* hw/meter_spi_regs.svh */
// Register offsets, field positions, reset values and widths of the metering serial port.
`ifndef METER_SPI_REGS_SVH
`define METER_SPI_REGS_SVH

`define ADDR_SAMPLED_WAVEFORM 6'h01
`define ADDR_ACTIVE_ENERGY 6'h02
`define ADDR_ACTIVE_ENERGY_CLR 6'h03
`define ADDR_LINE_ENERGY 6'h04
`define ADDR_APPARENT_ENERGY 6'h05
`define ADDR_APPARENT_ENERGY_CLR 6'h06
`define ADDR_MODE 6'h09
`define ADDR_IRQ_ENABLE 6'h0A

`define MODE_RESET 16'h000C
`define IRQ_ENABLE_RESET 16'h0040
`define ENERGY_RESET 24'h00_0000
`define CHECKSUM_RESET 6'h00

`define CMD_WRITE_BIT 7
`define CMD_ADDR_MSB 5
`define WAVE_SAMPLE_ENABLE_BIT 3
`define WAVE_SELECT_MSB 14
`define WAVE_SELECT_LSB 13

`define WIDTH_WIDE 5'h18
`define WIDTH_MODE 5'h10
`define WIDTH_BYTE 5'h08
`define BYTES_WIDE 2'h3
`define BYTES_MODE 2'h2
`define BYTES_BYTE 2'h1
`define LAST_BIT_OF_BYTE 3'h7

`endif

/* hw/meter_spi_pkg.sv */
// Types shared by the metering serial register port.
package meter_spi_pkg;

	typedef enum logic [1:0] {
		PORT_CMD,
		PORT_WRITE,
		PORT_READ
	} port_state_type;

	typedef struct packed {
		logic csN;
		logic sclk;
		logic din;
	} serial_pins_type;

	typedef struct packed {
		logic [23:0] activePower;
		logic [23:0] apparentPower;
		logic powerValid;
		logic [23:0] ch1Sample;
		logic [23:0] ch2Sample;
		logic sampleValid;
		logic halfCycleTick;
		logic [15:0] halfCycleCount;
	} meter_feed_type;

endpackage

/* hw/metering_serial_register_port.sv */
// Serial slave port with the energy and waveform registers it reaches.
`timescale 1ns/1ps
`include "meter_spi_regs.svh"

// Operation
// [R1] Capture data-in on serial clock falling edge.
// [R2] Change data-out after serial clock rising edge.
// [R3] Chip select fall resets port to command mode.
// [R4] Chip select rise aborts, floats data-out.
// [R5] Host finishes transfers when select tied low.
// [R6] Command bit7 one selects register write.
// [R7] Command bit7 zero selects register read.
// [R8] Eight-bit command, six low bits address.
// [R9] Bytewise write, first byte most significant.
// [R10] Data right-justified; excess upper bits discarded.
// [R11] Host spaces write bytes four microseconds.
// [R12] Aborted partial byte never updates register.
// [R13] Read drives data-out from next rising edge.
// [R14] Read end: command mode, float on fall.
// [R15] Float data-out on chip select rise.
// [R16] Read captures whole register at once.
// [R17] Host waits four microseconds before read.
// [R18] Host starts every read with command.
// [R19] Host keeps 2600 ns gap, 100 ns select-high.
// [R20] Checksum cleared, then counts ones sent.
// [R21] Clear-on-read energy registers zeroed after read.
// [R22] Line energy accumulates over half cycles.
// [R23] Mode bits pick waveform source; enable gates.
// [R24] Select high: ignore clock, float data-out.
module metering_serial_register_port (
	input wire logic clk,
	input wire logic nrst,
	input wire meter_spi_pkg::serial_pins_type pins,
	input wire meter_spi_pkg::meter_feed_type feed,
	output logic dout,
	output logic doutEn,
	output logic [5:0] checksum
);
	import meter_spi_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection.

	serial_pins_type pinsMeta_q;
	serial_pins_type pinsSync_q;
	logic sclkPrev_q;
	logic csNPrev_q;
	logic sclkRise;
	logic sclkFall;
	logic csFall;
	logic csHigh;

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			pinsMeta_q <= '{csN: 1'b1, sclk: 1'b1, din: 1'b0};
			pinsSync_q <= '{csN: 1'b1, sclk: 1'b1, din: 1'b0};
			sclkPrev_q <= 1'b1;
			csNPrev_q <= 1'b1;
		end
		else
		begin
			pinsMeta_q <= pins;
			pinsSync_q <= pinsMeta_q;
			sclkPrev_q <= pinsSync_q.sclk;
			csNPrev_q <= pinsSync_q.csN;
		end
	end

	// Clock edges only count while selected, so activity with select high is ignored.
	assign csHigh = pinsSync_q.csN; // [R24]
	assign sclkRise = !csHigh && pinsSync_q.sclk && !sclkPrev_q;
	assign sclkFall = !csHigh && !pinsSync_q.sclk && sclkPrev_q;
	assign csFall = !pinsSync_q.csN && csNPrev_q;

	////////////////////////////////////////////////////////////////////////////////
	// Register widths and the read multiplexer.

	logic [23:0] waveform_q;
	logic [23:0] activeEnergy_q;
	logic [23:0] activeEnergyClr_q;
	logic [23:0] lineEnergy_q;
	logic [23:0] apparentEnergy_q;
	logic [23:0] apparentEnergyClr_q;
	logic [15:0] mode_q;
	logic [15:0] irqEnable_q;

	function automatic logic [4:0] regWidth(input logic [5:0] addr);
		case (addr)
			`ADDR_SAMPLED_WAVEFORM, `ADDR_ACTIVE_ENERGY, `ADDR_ACTIVE_ENERGY_CLR,
			`ADDR_LINE_ENERGY, `ADDR_APPARENT_ENERGY, `ADDR_APPARENT_ENERGY_CLR: regWidth = `WIDTH_WIDE;
			`ADDR_MODE, `ADDR_IRQ_ENABLE: regWidth = `WIDTH_MODE;
			default: regWidth = `WIDTH_BYTE;
		endcase
	endfunction

	function automatic logic [1:0] regBytes(input logic [5:0] addr);
		case (regWidth(addr))
			`WIDTH_WIDE: regBytes = `BYTES_WIDE;
			`WIDTH_MODE: regBytes = `BYTES_MODE;
			default: regBytes = `BYTES_BYTE;
		endcase
	endfunction

	// The read value is left-aligned so the register's MSB leaves first.
	logic [23:0] readAligned;
	logic [5:0] cmdAddr;

	always_comb
	begin
		case (cmdAddr)
			`ADDR_SAMPLED_WAVEFORM: readAligned = waveform_q;
			`ADDR_ACTIVE_ENERGY: readAligned = activeEnergy_q;
			`ADDR_ACTIVE_ENERGY_CLR: readAligned = activeEnergyClr_q;
			`ADDR_LINE_ENERGY: readAligned = lineEnergy_q;
			`ADDR_APPARENT_ENERGY: readAligned = apparentEnergy_q;
			`ADDR_APPARENT_ENERGY_CLR: readAligned = apparentEnergyClr_q;
			`ADDR_MODE: readAligned = {mode_q, 8'h00};
			`ADDR_IRQ_ENABLE: readAligned = {irqEnable_q, 8'h00};
			default: readAligned = 24'h00_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial port sequencer.

	port_state_type state_q;
	logic [7:0] cmdShift_q;
	logic [4:0] bitCnt_q;
	logic [4:0] readLen_q;
	logic [5:0] addr_q;
	logic [1:0] bytesLeft_q;
	logic [23:0] shift_q;
	logic cmdDone;
	logic readStart;
	logic readDone;
	logic byteDone;
	logic commit_q;
	logic [1:0] commitLane_q;
	logic [7:0] commitByte_q;
	logic [5:0] commitAddr_q;
	logic clearOnRead_q;

	assign cmdAddr = {cmdShift_q[`CMD_ADDR_MSB-1:0], pinsSync_q.din};
	assign cmdDone = state_q == PORT_CMD && sclkFall && bitCnt_q[2:0] == `LAST_BIT_OF_BYTE;
	assign readStart = cmdDone && !cmdShift_q[`CMD_WRITE_BIT-1]; // [R7]
	assign readDone = state_q == PORT_READ && sclkFall && bitCnt_q == readLen_q;
	assign byteDone = state_q == PORT_WRITE && sclkFall && bitCnt_q[2:0] == `LAST_BIT_OF_BYTE;

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state_q <= PORT_CMD;
			cmdShift_q <= 8'h00;
			bitCnt_q <= 5'h00;
			readLen_q <= 5'h00;
			addr_q <= 6'h00;
			bytesLeft_q <= 2'h0;
		end
		else if (csHigh || csFall)
		begin
			state_q <= PORT_CMD; // [R3] [R4]
			bitCnt_q <= 5'h00;
		end
		else if (state_q == PORT_CMD && sclkFall)
		begin
			cmdShift_q <= {cmdShift_q[6:0], pinsSync_q.din}; // [R1]
			bitCnt_q <= bitCnt_q + 5'h01;
			if (cmdDone)
			begin
				bitCnt_q <= 5'h00;
				addr_q <= cmdAddr; // [R8]
				bytesLeft_q <= regBytes(cmdAddr);
				readLen_q <= regWidth(cmdAddr);
				state_q <= cmdShift_q[`CMD_WRITE_BIT-1] ? PORT_WRITE : PORT_READ; // [R6] [R7]
			end
		end
		else if (state_q == PORT_WRITE && sclkFall)
		begin
			bitCnt_q <= bitCnt_q + 5'h01;
			if (byteDone)
			begin
				bitCnt_q <= 5'h00;
				bytesLeft_q <= bytesLeft_q - 2'h1;
				if (bytesLeft_q == `BYTES_BYTE)
				begin
					state_q <= PORT_CMD;
				end
			end
		end
		else if (state_q == PORT_READ)
		begin
			if (sclkRise)
			begin
				bitCnt_q <= bitCnt_q + 5'h01;
			end
			if (readDone)
			begin
				state_q <= PORT_CMD; // [R14]
				bitCnt_q <= 5'h00;
			end
		end
	end

	// Each complete byte is committed at once; a byte cut short by select never reaches here.
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			commit_q <= 1'b0;
			commitLane_q <= 2'h0;
			commitByte_q <= 8'h00;
			commitAddr_q <= 6'h00;
		end
		else
		begin
			commit_q <= byteDone && !csHigh; // [R9] [R12]
			commitLane_q <= bytesLeft_q - 2'h1;
			commitByte_q <= {shift_q[6:0], pinsSync_q.din};
			commitAddr_q <= addr_q;
		end
	end

	// Write data and read data share one shift register.
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			shift_q <= 24'h00_0000;
			dout <= 1'b0;
			doutEn <= 1'b0;
			checksum <= `CHECKSUM_RESET;
			clearOnRead_q <= 1'b0;
		end
		else
		begin
			clearOnRead_q <= readDone && (addr_q == `ADDR_ACTIVE_ENERGY_CLR || addr_q == `ADDR_APPARENT_ENERGY_CLR);
			if (csHigh || csFall)
			begin
				doutEn <= 1'b0; // [R15] [R24]
			end
			else if (readStart)
			begin
				shift_q <= readAligned; // [R16]
				checksum <= `CHECKSUM_RESET; // [R20]
			end
			else if (state_q == PORT_WRITE && sclkFall)
			begin
				shift_q <= {shift_q[22:0], pinsSync_q.din}; // [R1]
			end
			else if (state_q == PORT_READ && sclkRise)
			begin
				dout <= shift_q[23]; // [R2] [R13]
				doutEn <= 1'b1;
				shift_q <= {shift_q[22:0], 1'b0};
				checksum <= checksum + {5'h00, shift_q[23]}; // [R20]
			end
			else if (readDone)
			begin
				doutEn <= 1'b0; // [R14]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Writable registers; bytes land in their lane, so short registers keep only low bits.

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			mode_q <= `MODE_RESET;
			irqEnable_q <= `IRQ_ENABLE_RESET;
		end
		else if (commit_q)
		begin
			if (commitAddr_q == `ADDR_MODE)
			begin
				if (commitLane_q == 2'h1)
					mode_q[15:8] <= commitByte_q; // [R9] [R10]
				else
					mode_q[7:0] <= commitByte_q;
			end
			if (commitAddr_q == `ADDR_IRQ_ENABLE)
			begin
				if (commitLane_q == 2'h1)
					irqEnable_q[15:8] <= commitByte_q; // [R9] [R10]
				else
					irqEnable_q[7:0] <= commitByte_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Energy accumulation and waveform capture.

	logic [23:0] activeInc;
	logic [23:0] apparentInc;
	logic [15:0] halfCnt_q;
	logic [23:0] lineAcc_q;

	assign activeInc = feed.powerValid ? feed.activePower : 24'h00_0000;
	assign apparentInc = feed.powerValid ? feed.apparentPower : 24'h00_0000;

	// A clear and a new increment in the same cycle keep the increment.
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			activeEnergy_q <= `ENERGY_RESET;
			activeEnergyClr_q <= `ENERGY_RESET;
			apparentEnergy_q <= `ENERGY_RESET;
			apparentEnergyClr_q <= `ENERGY_RESET;
		end
		else
		begin
			activeEnergy_q <= activeEnergy_q + activeInc;
			apparentEnergy_q <= apparentEnergy_q + apparentInc;
			if (clearOnRead_q && addr_q == `ADDR_ACTIVE_ENERGY_CLR)
				activeEnergyClr_q <= activeInc; // [R21]
			else
				activeEnergyClr_q <= activeEnergyClr_q + activeInc;
			if (clearOnRead_q && addr_q == `ADDR_APPARENT_ENERGY_CLR)
				apparentEnergyClr_q <= apparentInc; // [R21]
			else
				apparentEnergyClr_q <= apparentEnergyClr_q + apparentInc;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			halfCnt_q <= 16'h0000;
			lineAcc_q <= `ENERGY_RESET;
			lineEnergy_q <= `ENERGY_RESET;
		end
		else if (feed.halfCycleTick && halfCnt_q + 16'h0001 >= feed.halfCycleCount)
		begin
			lineEnergy_q <= lineAcc_q + activeInc; // [R22]
			lineAcc_q <= `ENERGY_RESET;
			halfCnt_q <= 16'h0000;
		end
		else
		begin
			lineAcc_q <= lineAcc_q + activeInc; // [R22]
			if (feed.halfCycleTick)
				halfCnt_q <= halfCnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			waveform_q <= `ENERGY_RESET;
		end
		else if (feed.sampleValid && irqEnable_q[`WAVE_SAMPLE_ENABLE_BIT])
		begin
			case (mode_q[`WAVE_SELECT_MSB:`WAVE_SELECT_LSB]) // [R23]
				2'h2: waveform_q <= feed.ch1Sample;
				2'h3: waveform_q <= feed.ch2Sample;
				default: waveform_q <= feed.activePower;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	sample_on_fall_a: assert property (state_q == PORT_CMD && sclkFall && !cmdDone |=>
		cmdShift_q[0] == $past(pinsSync_q.din)) else $error("command bit not taken on fall"); // [R1]
	drive_on_rise_a: assert property (state_q == PORT_READ && sclkRise && !readDone |=>
		doutEn && dout == $past(shift_q[23])) else $error("read bit not driven after rise"); // [R2]
	select_fall_reset_a: assert property (csFall |=> state_q == PORT_CMD && bitCnt_q == 5'h00)
		else $error("select fall did not reset port"); // [R3]
	select_high_float_a: assert property (csHigh |=> !doutEn && state_q == PORT_CMD)
		else $error("output driven while deselected"); // [R4]
	command_direction_a: assert property (cmdDone && !csHigh |=>
		state_q == ($past(cmdShift_q[6]) ? PORT_WRITE : PORT_READ) && addr_q == $past(cmdAddr))
		else $error("command decoded wrongly"); // [R6]
	read_end_float_a: assert property (readDone |=> !doutEn && state_q == PORT_CMD)
		else $error("read end did not float output"); // [R14]
	read_snapshot_a: assert property (readStart |=> shift_q == $past(readAligned) && checksum == 6'h00)
		else $error("read snapshot or checksum clear missing"); // [R16]
	mode_whole_byte_a: assert property ($changed(mode_q) |-> $past(commit_q) && $past(commitAddr_q) == `ADDR_MODE)
		else $error("mode changed without a whole byte"); // [R12]
	clear_on_read_a: assert property (readDone && addr_q == `ADDR_ACTIVE_ENERGY_CLR ##1 !feed.powerValid |=>
		activeEnergyClr_q == 24'h00_0000) else $error("clear-on-read register kept value"); // [R21]
	wave_gate_a: assert property ($changed(waveform_q) |-> $past(irqEnable_q[`WAVE_SAMPLE_ENABLE_BIT]))
		else $error("waveform sampled while disabled"); // [R23]
	checksum_count_a: assert property (state_q == PORT_READ && sclkRise && !csHigh |=>
		checksum == $past(checksum) + {5'h00, $past(shift_q[23])}) else $error("checksum not counting"); // [R20]

	read_done_c: cover property (readDone);
	write_commit_c: cover property (commit_q && commitAddr_q == `ADDR_MODE);
	read_abort_c: cover property (state_q == PORT_READ && doutEn ##1 csHigh);
	clear_read_c: cover property (clearOnRead_q);

endmodule

/* verification/serial_host_model.sv */
// Behavioural host that masters the serial register port.
`timescale 1ns/1ps
module serial_host_model (
	input wire logic clk,
	output meter_spi_pkg::serial_pins_type pins,
	input wire logic dout,
	input wire logic doutEn,
	output logic enAtEnd
);
	import meter_spi_pkg::*;

	logic lineLast = 1'b0;
	logic line;

	initial pins = 3'b110;
	initial enAtEnd = 1'b0;

	// A floating data line shows the inverse of its last level, so a stale bit can never pass as a good one.
	always @(posedge clk)
		if (doutEn)
			lineLast <= dout;
	assign line = doutEn ? dout : ~lineLast;

	////////////////////////////////////////////////////////////////////////////////
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Sends a command byte and nBits of data; an abortAt below 8 + nBits raises select before that bit.
	task automatic xfer(input logic [7:0] cmd, input int nBits, input logic [23:0] wData, input int abortAt,
		output logic [23:0] rData);
		logic [31:0] frame;
		int i;
		frame = {cmd, 24'(wData << (24 - nBits))};
		rData = 24'h00_0000;
		pins.csN <= 1'b0;
		wait_clk(4);
		for (i = 0; i < 8 + nBits; i++)
		begin
			if (i == abortAt)
				break;
			pins.din <= frame[31 - i];
			wait_clk(12);
			if (i >= 8)
				rData = {rData[22:0], line};
			pins.sclk <= 1'b0;
			wait_clk(13);
			pins.sclk <= 1'b1;
			if (cmd[7] && i >= 8 && i < 7 + nBits && (i - 7) % 8 == 0)
				wait_clk(800);
		end
		if (abortAt < 8 + nBits)
			pins.csN <= 1'b1;
		wait_clk(8);
		enAtEnd = doutEn;
		pins.csN <= 1'b1;
		// A read may only follow a write after the full commit time, so writes leave the longer gap.
		wait_clk(cmd[7] ? 800 : 520);
	endtask

	// Toggles clock and data while deselected.
	task automatic noise();
		int i;
		for (i = 0; i < 16; i++)
		begin
			pins.sclk <= i[0];
			pins.din <= i[1];
			wait_clk(12);
		end
		pins.sclk <= 1'b1;
		wait_clk(520);
	endtask
endmodule

/* verification/metering_serial_register_port_test.sv */
// Self-checking bench for the metering serial register port.
`timescale 1ns/1ps
`include "meter_spi_regs.svh"
module metering_serial_register_port_test;
	import meter_spi_pkg::*;

	logic clk = 1'b0;
	logic nrst = 1'b0;
	serial_pins_type pins;
	meter_feed_type feed = '0;
	logic dout;
	logic doutEn;
	logic enAtEnd;
	logic [5:0] checksum;
	logic [23:0] rd;
	int failCount = 0;
	int nCompared = 0;
	int cycles = 0;

	always #2.5 clk = ~clk;

	metering_serial_register_port i_dut (.clk(clk), .nrst(nrst), .pins(pins), .feed(feed), .dout(dout),
		.doutEn(doutEn), .checksum(checksum));
	serial_host_model i_host (.clk(clk), .pins(pins), .dout(dout), .doutEn(doutEn), .enAtEnd(enAtEnd));

	////////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("compared %0d, mismatches %0d", nCompared, failCount);
		if (failCount == 0 && nCompared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		nCompared++;
		if (seen !== exp)
		begin
			failCount++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic int width_of(input logic [5:0] addr);
		if (addr >= `ADDR_SAMPLED_WAVEFORM && addr <= `ADDR_APPARENT_ENERGY_CLR)
			return 24;
		return (addr == `ADDR_MODE || addr == `ADDR_IRQ_ENABLE) ? 16 : 8;
	endfunction

	task automatic write_reg(input logic [5:0] addr, input logic [23:0] val);
		logic [23:0] unused;
		i_host.xfer({2'b10, addr}, width_of(addr), val, 99, unused);
	endtask

	task automatic expect_reg(input logic [5:0] addr, input logic [23:0] exp);
		logic [23:0] val;
		i_host.xfer({2'b00, addr}, width_of(addr), 24'h00_0000, 99, val);
		check(val, exp);
		check({18'h0_0000, checksum}, 24'($countones(exp)));
		check({23'h00_0000, enAtEnd}, 24'h00_0000);
	endtask

	task automatic pulse(input logic [23:0] act, input logic [23:0] app, input logic isSample);
		@(posedge clk);
		feed.activePower <= act;
		feed.apparentPower <= app;
		feed.powerValid <= ~isSample;
		feed.sampleValid <= isSample;
		@(posedge clk);
		feed.powerValid <= 1'b0;
		feed.sampleValid <= 1'b0;
	endtask

	task automatic tick();
		@(posedge clk);
		feed.halfCycleTick <= 1'b1;
		@(posedge clk);
		feed.halfCycleTick <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// The ceiling sits well above the roughly 50000 cycles the sequence needs.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			failCount++;
			summarize();
		end
	end

	initial
	begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		for (int a = 1; a <= 6; a++)
			expect_reg(6'(a), `ENERGY_RESET);
		expect_reg(`ADDR_MODE, 24'(`MODE_RESET));
		expect_reg(`ADDR_IRQ_ENABLE, 24'(`IRQ_ENABLE_RESET));
		expect_reg(6'h20, 24'h00_0000);
		write_reg(`ADDR_MODE, 24'h00_A5C3);
		expect_reg(`ADDR_MODE, 24'h00_A5C3);
		write_reg(`ADDR_ACTIVE_ENERGY, 24'h12_3456);
		expect_reg(`ADDR_ACTIVE_ENERGY, 24'h00_0000);
		i_host.noise();
		check({23'h00_0000, doutEn}, 24'h00_0000);
		expect_reg(`ADDR_MODE, 24'h00_A5C3);
		// Cut inside the first data byte, then inside the second one.
		i_host.xfer({2'b10, `ADDR_MODE}, 16, 24'h00_3C5A, 12, rd);
		expect_reg(`ADDR_MODE, 24'h00_A5C3);
		i_host.xfer({2'b10, `ADDR_MODE}, 16, 24'h00_3C5A, 20, rd);
		expect_reg(`ADDR_MODE, 24'h00_3CC3);
		i_host.xfer({2'b00, `ADDR_MODE}, 16, 24'h00_0000, 14, rd);
		check({23'h00_0000, enAtEnd}, 24'h00_0000);
		expect_reg(`ADDR_MODE, 24'h00_3CC3);
		pulse(24'h00_0100, 24'h00_0200, 1'b0);
		pulse(24'h00_0100, 24'h00_0200, 1'b0);
		expect_reg(`ADDR_ACTIVE_ENERGY, 24'h00_0200);
		expect_reg(`ADDR_ACTIVE_ENERGY_CLR, 24'h00_0200);
		expect_reg(`ADDR_ACTIVE_ENERGY_CLR, 24'h00_0000);
		expect_reg(`ADDR_APPARENT_ENERGY_CLR, 24'h00_0400);
		expect_reg(`ADDR_APPARENT_ENERGY_CLR, 24'h00_0000);
		// An increment landing mid-read must not show in the bits already snapped.
		fork
			expect_reg(`ADDR_ACTIVE_ENERGY, 24'h00_0200);
			begin
				repeat (400) @(posedge clk);
				pulse(24'h00_0100, 24'h00_0100, 1'b0);
			end
		join
		expect_reg(`ADDR_ACTIVE_ENERGY, 24'h00_0300);
		expect_reg(`ADDR_APPARENT_ENERGY, 24'h00_0500);
		write_reg(`ADDR_IRQ_ENABLE, 24'h00_0048);
		write_reg(`ADDR_MODE, 24'h00_4000);
		feed.ch1Sample <= 24'h13_579B;
		feed.ch2Sample <= 24'h24_68AC;
		pulse(24'h00_0100, 24'h00_0000, 1'b1);
		expect_reg(`ADDR_SAMPLED_WAVEFORM, 24'h13_579B);
		write_reg(`ADDR_MODE, 24'h00_6000);
		pulse(24'h00_0100, 24'h00_0000, 1'b1);
		expect_reg(`ADDR_SAMPLED_WAVEFORM, 24'h24_68AC);
		// Two half cycles per period: the first period flushes what built up before, the second holds one step.
		feed.halfCycleCount <= 16'h0002;
		tick();
		tick();
		pulse(24'h00_0100, 24'h00_0000, 1'b0);
		tick();
		tick();
		expect_reg(`ADDR_LINE_ENERGY, 24'h00_0100);
		summarize();
	end
endmodule
